// ==== hdl/fpt_pipeline.sv ====
// floating-point coprocessor pipeline: issue, scoreboard, 7-stage
// arithmetic pipe, load pipe, forwarding and precise exceptions
// assumes the coprocessor interface unit holds each request until taken
//
// Operation
// - fpu cycle equals core clock, half, or two thirds at build time
// - instructions and data cross a 64-bit coprocessor interface
// - all latency and repeat counts tick in fpu cycles
// - fused multiply-add rounds product first, same as separate ops
// - flush-to-zero control replaces denormal add, sub, multiply, fused and convert results with zero
// - separate load/store and arithmetic pipes, never stalled by core
// - arithmetic completes in order, loads may complete out of order
// - core does memory access; load data accepted in any order
// - exceptions precise: nothing younger in the arithmetic pipe writes state
// - seven stages: decode, mul tree, mul done, add, add, pack, write
// - double multiply pumps the multiply tree twice
// - results forwarded to dependents before register writeback
// - latency counts cycles until a dependent may use the result
// - sign ops, add, sub, compare, single multiply: latency 4, rate 1
// - conversions: latency 4, rate 1
// - double multiply and double fused ops: latency 5, rate 2
// - moves to fpu and loads: latency 4, rate 1
// - moves from fpu and stores: latency 1, rate 1
`timescale 1ns/1ps
module fpt_pipeline
  import fpt_pkg::*;
#(
  parameter fpt_ratio_t RATIO = RATIO_HALF
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // control
  input  wire logic              flushToZero,
  // instruction request
  input  wire logic              insValid,
  output logic                   insReady,
  input  wire fpt_op_t           insOp,
  input  wire logic              insDouble,
  input  wire logic [REG_W-1:0]  insDst,
  input  wire logic [REG_W-1:0]  insSrcA,
  input  wire logic [REG_W-1:0]  insSrcB,
  input  wire logic [REG_W-1:0]  insSrcC,
  input  wire logic [DATA_W-1:0] insData,
  // load data
  input  wire logic              ldValid,
  output logic                   ldReady,
  input  wire logic [REG_W-1:0]  ldDst,
  input  wire logic [DATA_W-1:0] ldData,
  // store and move-from data
  output logic                   stValid,
  output logic [DATA_W-1:0]      stData,
  // exception
  output logic                   excValid,
  output logic [REG_W-1:0]       excDst,
  input  wire logic              excAck
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [DATA_W-1:0] regFile   [REG_CNT];
  logic [CNT_W-1:0]  busyCnt_r [REG_CNT];
  logic [REG_CNT-1:0] ldPend_r;
  logic              pVld_r    [PIPE_DEPTH];
  logic              pExc_r    [PIPE_DEPTH];
  logic [REG_W-1:0]  pDst_r    [PIPE_DEPTH];
  logic [DATA_W-1:0] pRes_r    [PIPE_DEPTH];
  logic              lVld_r    [LD_DEPTH];
  logic [REG_W-1:0]  lDst_r    [LD_DEPTH];
  logic [DATA_W-1:0] lDat_r    [LD_DEPTH];
  logic [CNT_W-1:0]  repCnt_r;
  logic              excValid_r;
  logic [REG_W-1:0]  excDst_r;
  logic              stValid_r;
  logic [DATA_W-1:0] stData_r;
  logic              fpuTick;

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic isNan(input logic [DATA_W-1:0] x,
                                 input logic dbl);
    if (dbl) begin
      isNan = (&x[DP_EXP_MSB:DP_EXP_LSB]) && (|x[DP_EXP_LSB-1:0]);
    end else begin
      isNan = (&x[SP_EXP_MSB:SP_EXP_LSB]) && (|x[SP_EXP_LSB-1:0]);
    end
  endfunction

  function automatic logic [DATA_W-1:0] flushDenorm(
      input logic [DATA_W-1:0] x, input logic dbl, input logic ftz);
    flushDenorm = x;
    if (ftz && dbl && ~|x[DP_EXP_MSB:DP_EXP_LSB]) begin
      flushDenorm = {x[DP_SIGN], ZERO_WORD[DP_SIGN-1:0]};
    end else if (ftz && !dbl && ~|x[SP_EXP_MSB:SP_EXP_LSB]) begin
      flushDenorm = {32'h0, x[SP_SIGN], ZERO_WORD[SP_SIGN-1:0]};
    end
  endfunction

  // arithmetic stand-in: integer operators on the raw words
  function automatic logic [DATA_W-1:0] mulOp(
      input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
      input logic dbl);
    logic [DATA_W-1:0] lo;
    logic [DATA_W-1:0] hi;
    lo = a * {32'h0, b[31:0]};
    hi = a * {32'h0, b[63:32]};
    mulOp = dbl ? 64'(lo + {hi[31:0], 32'h0}) : {32'h0, lo[31:0]};
  endfunction

  // looks up a pending result in either pipe, newest first within each, arithmetic pipe over load pipe
  function automatic logic [DATA_W-1:0] readOperand(
      input logic [REG_W-1:0] src);
    readOperand = regFile[src];
    for (int i = LD_DEPTH - 1; i >= 0; i--) begin
      if (lVld_r[i] && lDst_r[i] == src) begin
        readOperand = lDat_r[i];
      end
    end
    for (int i = PIPE_DEPTH - 1; i >= 0; i--) begin
      if (pVld_r[i] && pDst_r[i] == src) begin
        readOperand = pRes_r[i];
      end
    end
  endfunction

  function automatic logic regBusy(input logic [REG_W-1:0] r);
    regBusy = (busyCnt_r[r] != 3'h0) || ldPend_r[r];
  endfunction

  // ****************************************************************
  // fpu cycle strobe
  // ****************************************************************
  // build-time ratio
  fpt_ratio_gen #(
    .RATIO   (RATIO)
  ) u_ratio (
    .clk     (clk),
    .nrst    (nrst),
    .fpuTick (fpuTick)
  );

  // ****************************************************************
  // decode and hazards
  // ****************************************************************
  wire needA     = !(insOp inside {OP_MTC, OP_LOAD});
  wire needB     = insOp inside {OP_ADD, OP_SUB, OP_CMP, OP_MUL,
                                 OP_MADD, OP_MSUB};
  wire needC     = insOp inside {OP_MADD, OP_MSUB};
  wire isStore   = insOp inside {OP_MFC, OP_STORE};
  wire hasDst    = !isStore;
  wire isSlowMul = insDouble && (insOp inside {OP_MUL, OP_MADD, OP_MSUB});
  wire isArith   = insOp inside {OP_ADD, OP_SUB, OP_CMP, OP_MUL,
                                 OP_MADD, OP_MSUB, OP_CVT};
  wire [CNT_W-1:0] opLat = isSlowMul ? LAT_DMUL
                         : (insOp == OP_MTC) ? LAT_LOAD
                         : isStore ? LAT_STORE : LAT_SIMPLE;
  logic              srcHaz;
  logic              dstHaz;
  logic [DATA_W-1:0] opA;
  logic [DATA_W-1:0] opB;
  logic [DATA_W-1:0] opC;
  // lookups read pipe state beyond their arguments, so a process it is
  always_comb begin
    srcHaz = (needA && regBusy(insSrcA)) || (needB && regBusy(insSrcB))
           || (needC && regBusy(insSrcC));
    dstHaz = hasDst && regBusy(insDst);
    opA    = readOperand(insSrcA);
    opB    = readOperand(insSrcB);
    opC    = readOperand(insSrcC);
  end
  wire repHaz = isSlowMul && (repCnt_r != 3'h0);
  assign insReady = fpuTick && !excValid_r && !srcHaz && !dstHaz && !repHaz;
  wire issue      = insValid && insReady;
  assign ldReady  = fpuTick;
  wire ldTake     = ldValid && ldReady;

  // ****************************************************************
  // result formation
  // ****************************************************************
  // product rounded before add
  wire [DATA_W-1:0] prodRnd = flushDenorm(mulOp(opA, opB, insDouble),
                                          insDouble, flushToZero);
  wire [DATA_W-1:0] signBit = insDouble ? 64'h8000000000000000
                                        : 64'h0000000080000000;
  logic [DATA_W-1:0] rawRes;
  always_comb begin
    case (insOp)
      OP_ABS:  rawRes = opA & ~signBit;
      OP_NEG:  rawRes = opA ^ signBit;
      OP_ADD:  rawRes = 64'(opA + opB);
      OP_SUB:  rawRes = 64'(opA - opB);
      OP_CMP:  rawRes = {63'h0, opA == opB};
      OP_MUL:  rawRes = prodRnd;
      OP_MADD: rawRes = 64'(prodRnd + opC);
      OP_MSUB: rawRes = 64'(prodRnd - opC);
      OP_MTC:  rawRes = insData;
      default: rawRes = opA;
    endcase
  end
  wire [DATA_W-1:0] issueRes = (insOp inside {OP_ABS, OP_NEG, OP_MOV,
                                OP_MTC, OP_CMP}) ? rawRes
                             : flushDenorm(rawRes, insDouble, flushToZero);
  wire issueExc = isArith && (isNan(opA, insDouble)
                  || (needB && isNan(opB, insDouble)));

  wire wbVld  = pVld_r[STG_WRITEBACK];
  wire excHit = fpuTick && wbVld && pExc_r[STG_WRITEBACK];

  // ****************************************************************
  // arithmetic pipe
  // ****************************************************************
  // decode to writeback
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pVld_r[i] <= 1'b0;
        pExc_r[i] <= 1'b0;
        pDst_r[i] <= '0;
        pRes_r[i] <= '0;
      end
    end else if (fpuTick) begin
      pVld_r[STG_DECODE] <= issue && hasDst && insOp != OP_LOAD && !excHit;
      pExc_r[STG_DECODE] <= issueExc;
      pDst_r[STG_DECODE] <= insDst;
      pRes_r[STG_DECODE] <= issueRes;
      for (int i = STG_MUL_TREE; i < PIPE_DEPTH; i++) begin
        pVld_r[i] <= pVld_r[i-1] && !excHit;
        pExc_r[i] <= pExc_r[i-1];
        pDst_r[i] <= pDst_r[i-1];
        pRes_r[i] <= pRes_r[i-1];
      end
    end
  end

  // ****************************************************************
  // load pipe
  // ****************************************************************
  // 64-bit word taken
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < LD_DEPTH; i++) begin
        lVld_r[i] <= 1'b0;
        lDst_r[i] <= '0;
        lDat_r[i] <= '0;
      end
    end else if (fpuTick) begin
      lVld_r[0] <= ldTake;
      lDst_r[0] <= ldDst;
      lDat_r[0] <= ldData;
      for (int i = 1; i < LD_DEPTH; i++) begin
        lVld_r[i] <= lVld_r[i-1];
        lDst_r[i] <= lDst_r[i-1];
        lDat_r[i] <= lDat_r[i-1];
      end
    end
  end

  // ****************************************************************
  // register file writes
  // ****************************************************************
  // no reset: contents are undefined until first written
  always_ff @(posedge clk) begin
    if (fpuTick && wbVld && !pExc_r[STG_WRITEBACK]) begin
      regFile[pDst_r[STG_WRITEBACK]] <= pRes_r[STG_WRITEBACK];
    end
    if (fpuTick && lVld_r[LD_DEPTH-1]) begin
      regFile[lDst_r[LD_DEPTH-1]] <= lDat_r[LD_DEPTH-1];
    end
  end

  // ****************************************************************
  // scoreboard
  // ****************************************************************
  // counter reaches zero when usable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int r = 0; r < REG_CNT; r++) begin
        busyCnt_r[r] <= 3'h0;
      end
      ldPend_r <= '0;
    end else if (fpuTick) begin
      for (int r = 0; r < REG_CNT; r++) begin
        if (excHit) begin
          busyCnt_r[r] <= 3'h0;
        end else if (issue && hasDst && insOp != OP_LOAD
                     && insDst == REG_W'(r)) begin
          busyCnt_r[r] <= 3'(opLat - 3'h1);
        end else if (ldTake && ldDst == REG_W'(r)) begin
          busyCnt_r[r] <= 3'(LAT_LOAD - 3'h1);
        end else if (busyCnt_r[r] != 3'h0) begin
          busyCnt_r[r] <= 3'(busyCnt_r[r] - 3'h1);
        end
        if (ldTake && ldDst == REG_W'(r)) begin
          ldPend_r[r] <= 1'b0;
        end else if (issue && insOp == OP_LOAD && insDst == REG_W'(r)) begin
          ldPend_r[r] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      repCnt_r <= 3'h0;
    end else if (fpuTick) begin
      if (issue && isSlowMul) begin
        repCnt_r <= 3'(REP_DMUL - REP_SIMPLE);
      end else if (repCnt_r != 3'h0) begin
        repCnt_r <= 3'(repCnt_r - 3'h1);
      end
    end
  end

  // ****************************************************************
  // store and move-from output
  // ****************************************************************
  // one cycle to the core
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stValid_r <= 1'b0;
      stData_r  <= '0;
    end else begin
      stValid_r <= issue && isStore;
      if (issue && isStore) begin
        stData_r <= opA;
      end
    end
  end
  assign stValid = stValid_r;
  assign stData  = stData_r;

  // ****************************************************************
  // exception report
  // ****************************************************************
  // hold issue until acknowledged
  always_ff @(posedge clk) begin
    if (!nrst) begin
      excValid_r <= 1'b0;
      excDst_r   <= '0;
    end else if (excHit) begin
      excValid_r <= 1'b1;
      excDst_r   <= pDst_r[STG_WRITEBACK];
    end else if (excAck) begin
      excValid_r <= 1'b0;
    end
  end
  assign excValid = excValid_r;
  assign excDst   = excDst_r;

endmodule

// ==== hdl/fpt_pkg.sv ====
// package for the floating-point pipeline timing block
// assumes a single clock shared with the integer core interface
package fpt_pkg;

  // ****************************************************************
  // build-time clock ratio and operation classes
  // ****************************************************************
  typedef enum logic [1:0] {
    RATIO_FULL,
    RATIO_HALF,
    RATIO_TWO_THIRDS
  } fpt_ratio_t;

  typedef enum logic [3:0] {
    OP_ABS, OP_NEG, OP_MOV, OP_ADD, OP_SUB, OP_CMP, OP_MUL,
    OP_MADD, OP_MSUB, OP_CVT, OP_MTC, OP_LOAD, OP_MFC, OP_STORE
  } fpt_op_t;

  // ****************************************************************
  // widths and stage positions
  // ****************************************************************
  localparam int DATA_W        = 64;
  localparam int REG_CNT       = 32;
  localparam int REG_W         = 5;
  localparam int CNT_W         = 3;
  localparam int PIPE_DEPTH    = 7;
  localparam int STG_DECODE    = 0;
  localparam int STG_MUL_TREE  = 1;
  localparam int STG_MUL_DONE  = 2;
  localparam int STG_ADD_FIRST = 3;
  localparam int STG_ADD_FINAL = 4;
  localparam int STG_PACK      = 5;
  localparam int STG_WRITEBACK = 6;

  // ****************************************************************
  // latencies and repeat intervals, in fpu cycles
  // ****************************************************************
  localparam logic [CNT_W-1:0] LAT_SIMPLE = 3'h4;
  localparam logic [CNT_W-1:0] REP_SIMPLE = 3'h1;
  localparam logic [CNT_W-1:0] LAT_DMUL   = 3'h5;
  localparam logic [CNT_W-1:0] REP_DMUL   = 3'h2;
  localparam logic [CNT_W-1:0] LAT_LOAD   = 3'h4;
  localparam logic [CNT_W-1:0] LAT_STORE  = 3'h1;
  localparam int LD_DEPTH = 3;

  // ****************************************************************
  // ieee field positions
  // ****************************************************************
  localparam int SP_SIGN    = 31;
  localparam int SP_EXP_MSB = 30;
  localparam int SP_EXP_LSB = 23;
  localparam int DP_SIGN    = 63;
  localparam int DP_EXP_MSB = 62;
  localparam int DP_EXP_LSB = 52;
  localparam logic [DATA_W-1:0] ZERO_WORD = 64'h0;

endpackage

// ==== hdl/fpt_ratio_gen.sv ====
// fpu cycle strobe generator for the build-time clock ratio
// assumes clk is the integer core clock
`timescale 1ns/1ps
module fpt_ratio_gen
  import fpt_pkg::*;
#(
  parameter fpt_ratio_t RATIO = RATIO_HALF
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // fpu cycle strobe
  output logic      fpuTick
);

  logic [1:0] phase_r;
  logic [1:0] phase_nxt;

  // ****************************************************************
  // phase counter
  // ****************************************************************
  // ratio pattern select
  assign phase_nxt = (RATIO == RATIO_TWO_THIRDS && phase_r == 2'h2) ? 2'h0
                   : 2'(phase_r + 2'h1);
  assign fpuTick   = (RATIO == RATIO_FULL) ? 1'b1
                   : (RATIO == RATIO_HALF) ? phase_r[0]
                   : (phase_r != 2'h2);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

endmodule

// ==== verif/fpt_ciu_model.sv ====
// load data side of the coprocessor interface unit
// assumes send is called in the time step of a rising edge
`timescale 1ns/1ps
module fpt_ciu_model
  import fpt_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // load data
  output logic                   ldValid,
  input  wire logic              ldReady,
  output logic [REG_W-1:0]       ldDst,
  output logic [DATA_W-1:0]      ldData
);
  int cyc = 0;
  int lastTake = 0;
  initial begin
    ldValid = 1'b0;
    ldDst = '0;
    ldData = '0;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // core fetches the word, order and delay are ours
  task automatic send(input logic [REG_W-1:0] dst,
                      input logic [DATA_W-1:0] data, input int slow);
    int n;
    n = 0;
    repeat (slow) @(posedge clk);
    ldValid <= 1'b1;
    ldDst <= dst;
    ldData <= data;
    do begin
      @(negedge clk);
      n++;
    end while (ldReady !== 1'b1 && n < 50);
    @(posedge clk);
    lastTake = cyc;
    ldValid <= 1'b0;
    // released lines show the inverse, not a stale word
    ldDst <= ~dst;
    ldData <= ~data;
  endtask
endmodule

// ==== verif/fpt_pipeline_asserts.sv ====
// port checker for the fpu pipeline
// assumes a bind onto fpt_pipeline, one clock, sync reset
`timescale 1ns/1ps
module fpt_pipeline_asserts
  import fpt_pkg::*;
#(
  parameter fpt_ratio_t RATIO = RATIO_HALF
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              flushToZero,
  input wire logic              insValid,
  input wire logic              insReady,
  input wire fpt_op_t           insOp,
  input wire logic              insDouble,
  input wire logic [REG_W-1:0]  insDst,
  input wire logic [REG_W-1:0]  insSrcA,
  input wire logic [REG_W-1:0]  insSrcB,
  input wire logic [REG_W-1:0]  insSrcC,
  input wire logic [DATA_W-1:0] insData,
  input wire logic              ldValid,
  input wire logic              ldReady,
  input wire logic [REG_W-1:0]  ldDst,
  input wire logic [DATA_W-1:0] ldData,
  input wire logic              stValid,
  input wire logic [DATA_W-1:0] stData,
  input wire logic              excValid,
  input wire logic [REG_W-1:0]  excDst,
  input wire logic              excAck
);
  // ****************************************
  // minimum spacing in clocks per ratio
  // ****************************************
  localparam bit HALF = (RATIO == RATIO_HALF);
  localparam logic [3:0] DEP_CLKS = HALF ? 4'h8 :
    (RATIO == RATIO_FULL) ? 4'h4 : 4'h6;
  localparam logic [3:0] DMUL_CLKS = HALF ? 4'h4 :
    (RATIO == RATIO_FULL) ? 4'h2 : 4'h3;
  wire take = insValid && insReady;
  wire isDmul = insDouble && (insOp inside {OP_MUL, OP_MADD, OP_MSUB});
  wire dmulTake = take && isDmul;
  wire simpTake = take && !isDmul &&
    !(insOp inside {OP_LOAD, OP_STORE, OP_MFC});
  wire useA = take && !(insOp inside {OP_MTC, OP_LOAD});
  // ages saturate so an old producer never trips the check
  logic [3:0]       depAge_r;
  logic [3:0]       depAge_nxt;
  logic [3:0]       dmulAge_r;
  logic [3:0]       dmulAge_nxt;
  logic [REG_W-1:0] depDst_r;
  assign depAge_nxt = simpTake ? 4'h1 :
    depAge_r + {3'h0, depAge_r != 4'hf};
  assign dmulAge_nxt = dmulTake ? 4'h1 :
    dmulAge_r + {3'h0, dmulAge_r != 4'hf};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      depAge_r  <= 4'hf;
      dmulAge_r <= 4'hf;
      depDst_r  <= '0;
    end else begin
      depAge_r  <= depAge_nxt;
      dmulAge_r <= dmulAge_nxt;
      if (simpTake) depDst_r <= insDst;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_store_take;
    take && (insOp == OP_STORE || insOp == OP_MFC);
  endsequence
  AST_TICK_ALT: assert property (HALF && ldReady |=> !ldReady)
    else $error("fpu tick on two clocks in a row");
  AST_TICK_RUN: assert property
    (HALF && !ldReady && $past(nrst) |=> ldReady)
    else $error("fpu tick missing");
  AST_INS_ON_TICK: assert property (insReady |-> ldReady)
    else $error("issue outside fpu tick");
  AST_EXC_BLOCK: assert property (excValid |-> !insReady)
    else $error("issue while exception pending");
  AST_EXC_HOLD: assert property (excValid && !excAck |=> excValid)
    else $error("exception dropped without ack");
  AST_ST_ANSWER: assert property (s_store_take |=> stValid)
    else $error("store data not returned");
  AST_ST_PULSE: assert property (stValid |=> !stValid)
    else $error("store pulse doubled");
  AST_ST_DATA: assert property ($changed(stData) |-> stValid)
    else $error("store data moved without pulse");
  AST_DEP_LAT: assert property
    (useA && insSrcA == depDst_r |-> depAge_r >= DEP_CLKS)
    else $error("dependent issued before latency");
  AST_DMUL_RATE: assert property
    (dmulTake |-> dmulAge_r >= DMUL_CLKS)
    else $error("double multiply repeat too soon");
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the fpu pipeline at half ratio
// assumes the load side model and the bound port checker
`timescale 1ns/1ps
module tb_top
  import fpt_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam int CPT = 2;
  localparam int LIMIT = 3000;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             flushToZero = 1'b0;
  logic             insValid = 1'b0;
  logic             insReady;
  fpt_op_t          insOp = OP_ABS;
  logic             insDouble = 1'b0;
  logic [REG_W-1:0] insDst = '0, insSrcA = '0, insSrcB = '0, insSrcC = '0;
  logic [DATA_W-1:0] insData = '0;
  logic             ldValid, ldReady, stValid, excValid;
  logic             excAck = 1'b0;
  logic [REG_W-1:0] ldDst, excDst;
  logic [DATA_W-1:0] ldData, stData;
  int               cyc = 0;
  int               n_mismatch = 0;
  int               checked = 0;
  fpt_pipeline #(.RATIO(RATIO_HALF)) fpt_pipeline_inst (.clk(clk),
    .nrst(nrst), .flushToZero(flushToZero), .insValid(insValid),
    .insReady(insReady), .insOp(insOp), .insDouble(insDouble),
    .insDst(insDst), .insSrcA(insSrcA), .insSrcB(insSrcB),
    .insSrcC(insSrcC), .insData(insData), .ldValid(ldValid),
    .ldReady(ldReady), .ldDst(ldDst), .ldData(ldData),
    .stValid(stValid), .stData(stData), .excValid(excValid),
    .excDst(excDst), .excAck(excAck));
  fpt_ciu_model fpt_ciu_model_inst (.clk(clk), .nrst(nrst),
    .ldValid(ldValid), .ldReady(ldReady), .ldDst(ldDst), .ldData(ldData));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic conclude();
    $display("compared %0d mismatched %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_data(input string nm, input logic [DATA_W-1:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_cnt(input string nm, input int e, g);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
    end
  endtask
  // request held from a rising edge until taken
  task automatic issue(input fpt_op_t op, input logic dbl,
      input logic [REG_W-1:0] d, a, b, c, input logic [DATA_W-1:0] v,
      input bit hold, output int tk);
    int n;
    n = 0;
    insValid <= 1'b1;
    insOp <= op;
    insDouble <= dbl;
    insDst <= d;
    insSrcA <= a;
    insSrcB <= b;
    insSrcC <= c;
    insData <= v;
    do begin
      @(negedge clk);
      n++;
    end while (insReady !== 1'b1 && n < 100);
    @(posedge clk);
    tk = cyc;
    if (!hold) insValid <= 1'b0;
  endtask
  task automatic store_chk(input logic [REG_W-1:0] a,
      input logic [DATA_W-1:0] e, output int tk);
    issue(OP_STORE, 1'b0, 5'h0, a, 5'h0, 5'h0, 64'h0, 1'b0, tk);
    @(negedge clk);
    cmp_data("stValid", 64'h1, {63'h0, stValid});
    cmp_data("stData", e, stData);
    @(posedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_simple();
    int t1, t2, t3, t4;
    issue(OP_MTC, 1'b0, 5'h1, 5'h0, 5'h0, 5'h0, 64'h5, 1'b1, t1);
    issue(OP_MTC, 1'b0, 5'h2, 5'h0, 5'h0, 5'h0, 64'h7, 1'b1, t2);
    cmp_cnt("mtc repeat", CPT, t2 - t1);
    issue(OP_ADD, 1'b0, 5'h3, 5'h1, 5'h2, 5'h0, 64'h0, 1'b1, t3);
    cmp_cnt("mtc latency", CPT * int'(LAT_LOAD), t3 - t2);
    store_chk(5'h3, 64'hc, t4);
    cmp_cnt("add latency", CPT * int'(LAT_SIMPLE), t4 - t3);
    $display("test simple done");
  endtask
  task automatic t_ops();
    fpt_op_t ops[8] = '{OP_ABS, OP_NEG, OP_MOV, OP_SUB, OP_CMP, OP_MUL,
                        OP_CVT, OP_MSUB};
    // integer stand-in results for r1 = 5, r2 = 7
    logic [DATA_W-1:0] res[8] = '{64'h5, 64'h80000005, 64'h5,
      64'hfffffffffffffffe, 64'h0, 64'h23, 64'h5, 64'h1c};
    int ta, ts;
    foreach (ops[i]) begin
      issue(ops[i], 1'b0, 5'h10, 5'h1, 5'h2, 5'h2, 64'h0, 1'b1, ta);
      issue(OP_MFC, 1'b0, 5'h0, 5'h10, 5'h0, 5'h0, 64'h0, 1'b0, ts);
      cmp_cnt("op latency", CPT * int'(LAT_SIMPLE), ts - ta);
      @(negedge clk);
      cmp_data("mfc data", res[i], stData);
      @(posedge clk);
    end
    $display("test classes done");
  endtask
  task automatic t_dmul();
    int t1, t2, t3;
    issue(OP_MUL, 1'b1, 5'h4, 5'h1, 5'h2, 5'h0, 64'h0, 1'b1, t1);
    issue(OP_MADD, 1'b1, 5'h5, 5'h1, 5'h2, 5'h3, 64'h0, 1'b1, t2);
    cmp_cnt("dmul repeat", CPT * int'(REP_DMUL), t2 - t1);
    store_chk(5'h4, 64'h23, t3);
    cmp_cnt("dmul latency", CPT * int'(LAT_DMUL), t3 - t1);
    $display("test double done");
  endtask
  task automatic t_load();
    int t1, t2;
    issue(OP_LOAD, 1'b0, 5'h8, 5'h0, 5'h0, 5'h0, 64'h0, 1'b1, t1);
    issue(OP_LOAD, 1'b0, 5'h9, 5'h0, 5'h0, 5'h0, 64'h0, 1'b0, t1);
    fpt_ciu_model_inst.send(5'h9, 64'h99, 3);
    store_chk(5'h9, 64'h99, t2);
    t1 = fpt_ciu_model_inst.lastTake;
    cmp_cnt("load latency", CPT * int'(LAT_LOAD), t2 - t1);
    fpt_ciu_model_inst.send(5'h8, 64'h88, 0);
    store_chk(5'h8, 64'h88, t2);
    $display("test load done");
  endtask
  task automatic t_exc();
    int t, n;
    n = 0;
    issue(OP_MTC, 1'b0, 5'hc, 5'h0, 5'h0, 5'h0, 64'h11, 1'b1, t);
    issue(OP_MTC, 1'b0, 5'ha, 5'h0, 5'h0, 5'h0, 64'h7ff8000000000000,
          1'b1, t);
    issue(OP_ADD, 1'b1, 5'hb, 5'ha, 5'h1, 5'h0, 64'h0, 1'b1, t);
    issue(OP_MTC, 1'b0, 5'hc, 5'h0, 5'h0, 5'h0, 64'h55, 1'b0, t);
    do begin
      @(negedge clk);
      n++;
    end while (excValid !== 1'b1 && n < 40);
    cmp_data("excDst", 64'hb, {59'h0, excDst});
    repeat (3) @(posedge clk);
    excAck <= 1'b1;
    @(posedge clk);
    excAck <= 1'b0;
    @(negedge clk);
    cmp_data("excValid", 64'h0, {63'h0, excValid});
    @(posedge clk);
    store_chk(5'hc, 64'h11, t);
    $display("test exception done");
  endtask
  task automatic t_ftz();
    int t;
    issue(OP_MTC, 1'b0, 5'hd, 5'h0, 5'h0, 5'h0, 64'h1, 1'b1, t);
    issue(OP_CVT, 1'b0, 5'he, 5'hd, 5'h0, 5'h0, 64'h0, 1'b1, t);
    store_chk(5'he, 64'h1, t);
    flushToZero <= 1'b1;
    issue(OP_CVT, 1'b0, 5'hf, 5'hd, 5'h0, 5'h0, 64'h0, 1'b1, t);
    store_chk(5'hf, 64'h0, t);
    flushToZero <= 1'b0;
    $display("test flush done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_simple();
    t_ops();
    t_dmul();
    t_load();
    t_exc();
    t_ftz();
    conclude();
  end
endmodule
bind fpt_pipeline fpt_pipeline_asserts #(.RATIO(RATIO))
  fpt_pipeline_asserts_inst (.clk(clk), .nrst(nrst),
  .flushToZero(flushToZero), .insValid(insValid), .insReady(insReady),
  .insOp(insOp), .insDouble(insDouble), .insDst(insDst),
  .insSrcA(insSrcA), .insSrcB(insSrcB), .insSrcC(insSrcC),
  .insData(insData), .ldValid(ldValid), .ldReady(ldReady),
  .ldDst(ldDst), .ldData(ldData), .stValid(stValid), .stData(stData),
  .excValid(excValid), .excDst(excDst), .excAck(excAck));
